// File: rtl/cip_map.svh
`ifndef CIP_MAP_SVH
`define CIP_MAP_SVH

// ==========================================================================
// register indices (byte address on the bus is four times the index)
`define CIP_IDX_CTRL 6'h1E
`define CIP_IDX_FLAGS 6'h20
`define CIP_IDX_ENABLES 6'h21
`define CIP_IDX_TRIG_HI 6'h22
`define CIP_IDX_TRIG_LO 6'h23
`define CIP_IDX_MUTE_SUM 6'h28
`define CIP_IDX_AUX_FIRST 6'h29
`define CIP_IDX_AUX_LAST 6'h2F

// ==========================================================================
// field positions and writable masks
`define CIP_NUM_AUX 7
`define CIP_BIT_LOST_LOCK 7
`define CIP_BIT_RANGE 1
`define CIP_EVT_MASK 8'h82
`define CIP_CTRL_WMASK 8'hBC
`define CIP_MUTE_SUM_WMASK 8'h3F
`define CIP_STYLE_MSB 3
`define CIP_STYLE_LSB 2
`define CIP_POL_BIT 5

// ==========================================================================
// reset values
`define CIP_CTRL_RST 8'h00
`define CIP_ENABLES_RST 8'h00
`define CIP_TRIG_RST 8'h00
`define CIP_MUTE_SUM_RST 8'h1F
`define CIP_AUX_RST 8'h00

// ==========================================================================
// encodings
`define CIP_STYLE_HIGH 2'h0
`define CIP_STYLE_LOW 2'h1
`define CIP_STYLE_OD 2'h2
`define CIP_TRIG_RISE 2'h0
`define CIP_TRIG_FALL 2'h1
`define CIP_TRIG_LEVEL 2'h2
`define CIP_MODE_RSVD 2'h0
`define CIP_MODE_MUTE 2'h1
`define CIP_MODE_LOW_OVFL 2'h2
`define CIP_MODE_HIGH 2'h3
`define CIP_FUNC_LOW 2'h0
`define CIP_FUNC_OVFL 2'h3

// ==========================================================================
// channel masks per function bit, byte j belongs to function bit j;
// channel order in a mask byte is A1 B1 A2 B2 A3 B3 A4 B4 from bit 0 up
`define CIP_MAP_A 40'h01_020C_30C0
`define CIP_MAP_B 40'h03_0408_30C0
`define CIP_MAP_C 40'h03_0C10_20C0
`define CIP_MAP_D 40'h03_0C30_4080

`endif

// File: rtl/cip_pkg.sv
package cip_pkg;
`include "cip_map.svh"

   // address and data phase signals of the AHB-Lite master
   typedef struct packed {
      logic hsel;
      logic [7:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } cip_ahb_req_t;

   // raw conditions arriving from the converter and clock sections
   typedef struct packed {
      logic lost_lock;
      logic range_left;
      logic range_right;
      logic [7:0] chan_mute;
   } cip_src_t;

   // complete state of the block
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] flags;
      logic [7:0] enables;
      logic [7:0] trig_hi;
      logic [7:0] trig_lo;
      logic [7:0] mute_ctl;
      logic [`CIP_NUM_AUX-1:0][7:0] aux;
      logic [7:0] cond_prev;
      logic wr_pend;
      logic [5:0] wr_idx;
      logic [31:0] rdata;
      logic rdy;
      logic irq_pin;
      logic irq_oe;
      logic msum;
      logic [`CIP_NUM_AUX-1:0] aux_pin;
      logic [`CIP_NUM_AUX-1:0] aux_oe;
   } cip_state_t;

endpackage : cip_pkg

// File: rtl/cip_sync.sv
`timescale 1ns/1ps

module cip_sync #(
   parameter int W = 11
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } cip_sync_st_t;

   cip_sync_st_t s_r;
   cip_sync_st_t s_nxt;
   logic [W-1:0] q_nxt;

   // ==========================================================================
   // per bit filter: a change counts once stages two and three agree,
   // which rejects a single-cycle glitch at the cost of one more cycle
   for (genvar i = 0; i < W; i++) begin : g_bit
      assign q_nxt[i] = (s_r.s2[i] == s_r.s3[i]) ? s_r.s3[i] : s_r.q[i];
   end

   // shift chain; the first stage feeds only the second
   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = d_i;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      s_nxt.q = q_nxt;
   end

   // register the state
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q_o = s_r.q;

endmodule : cip_sync

// File: rtl/cip_irq_pins.sv
`timescale 1ns/1ps

`include "cip_map.svh"

module cip_irq_pins #(
   parameter int NUM_AUX = 7
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire cip_pkg::cip_ahb_req_t ahb_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire cip_pkg::cip_src_t src_i,
   output logic irq_pin_o,
   output logic irq_pin_oe_o,
   output logic mute_summary_o,
   output logic [NUM_AUX-1:0] aux_output_pin_o,
   output logic [NUM_AUX-1:0] aux_output_pin_oe_o
);

   // ==========================================================================
   // elaboration checks
   if (NUM_AUX != `CIP_NUM_AUX) begin : g_bad_aux
      $error("aux pin count must match the register map");
   end
   // the filter width must match the condition bundle bit for bit
   if ($bits(cip_pkg::cip_src_t) != 11) begin : g_bad_src
      $error("source bundle width must match the synchroniser");
   end
   // event bits must sit inside the byte-wide status register
   if (`CIP_BIT_LOST_LOCK > 7 || `CIP_BIT_RANGE > 7) begin : g_bad_bits
      $error("event bit positions must fit one byte");
   end

   // ==========================================================================
   // channel masks per aux pin, index k drives pin k+1
   // pins one and two, three and four, five and six share a grouping;
   // pin seven groups its channels like the summary pin
   function automatic logic [39:0] aux_map(input int k);
      logic [39:0] m;
      m = `CIP_MAP_A;
      if (k < 2) begin
         m = `CIP_MAP_D;
      end else if (k < 4) begin
         m = `CIP_MAP_C;
      end else if (k < 6) begin
         m = `CIP_MAP_B;
      end
      return m;
   endfunction : aux_map

   // ==========================================================================
   // reset image of the state
   // outputs start inactive: irq low in the active-high style, summary pin
   // high because its polarity resets to active low
   function automatic cip_pkg::cip_state_t rst_state();
      cip_pkg::cip_state_t r;
      r = '0;
      r.ctrl = `CIP_CTRL_RST;
      r.enables = `CIP_ENABLES_RST;
      r.trig_hi = `CIP_TRIG_RST;
      r.trig_lo = `CIP_TRIG_RST;
      r.mute_ctl = `CIP_MUTE_SUM_RST;
      for (int k = 0; k < `CIP_NUM_AUX; k++) begin
         r.aux[k] = `CIP_AUX_RST;
      end
      r.rdy = 1'h1;
      r.irq_oe = 1'h1;
      r.msum = 1'h1;
      return r;
   endfunction : rst_state

   localparam cip_pkg::cip_state_t RST_S = rst_state();

   cip_pkg::cip_state_t s_r;
   cip_pkg::cip_state_t s_nxt;
   cip_pkg::cip_src_t src_s;
   logic [10:0] src_raw;
   logic [7:0] cond_now;
   logic [7:0] evt;
   logic [4:0] sum_grp_ok;
   logic sum_act;
   logic range_any;
   logic [NUM_AUX-1:0] aux_lvl;
   logic [NUM_AUX-1:0] aux_en;
   logic acc;
   logic a_ok;
   logic [5:0] a_idx;
   logic [7:0] wb;
   logic [2:0] wk;
   logic [2:0] rk;
   logic [7:0] rd_byte;
   logic rd_clr;
   logic irq_act;

   // ==========================================================================
   // source conditions come from other clock domains, so filter them
   cip_sync #(
      .W(11)
   ) u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .d_i(src_i),
      .q_o(src_raw)
   );

   assign src_s = cip_pkg::cip_src_t'(src_raw);

   // over-range on either channel counts as one condition
   assign range_any = src_s.range_left | src_s.range_right;

   // condition vector at status bit positions
   always_comb begin
      cond_now = 8'h00;
      cond_now[`CIP_BIT_LOST_LOCK] = src_s.lost_lock;
      cond_now[`CIP_BIT_RANGE] = range_any;
   end

   // ==========================================================================
   // per source trigger detection, gated by its enable; only the defined
   // event positions can ever fire, the other bits stay at zero
   localparam logic [7:0] EVT_M = `CIP_EVT_MASK;
   for (genvar i = 0; i < 8; i++) begin : g_evt
      logic [1:0] code;
      logic hit;
      assign code = {s_r.trig_hi[i], s_r.trig_lo[i]};
      always_comb begin
         unique case (code)
            `CIP_TRIG_RISE: hit = cond_now[i] & ~s_r.cond_prev[i];
            `CIP_TRIG_FALL: hit = ~cond_now[i] & s_r.cond_prev[i];
            `CIP_TRIG_LEVEL: hit = cond_now[i];
            default: hit = 1'h0;
         endcase
      end
      // a masked source reaches neither the flags nor the pin
      assign evt[i] = hit & s_r.enables[i] & EVT_M[i];
   end

   // ==========================================================================
   // mute summary groups: each select bit covers a channel or a pair
   localparam logic [39:0] SUM_MAP = `CIP_MAP_A;
   for (genvar j = 0; j < 5; j++) begin : g_sum
      localparam logic [7:0] M = SUM_MAP[8*j +: 8];
      assign sum_grp_ok[j] = &(src_s.chan_mute | ~M);
   end

   // AND over selected groups; with none selected the AND is vacuously true
   assign sum_act = &(~s_r.mute_ctl[4:0] | sum_grp_ok);

   // ==========================================================================
   // aux pin drive, one slice per pin
   // a pin that is not driven relies on the board to hold a defined level
   for (genvar k = 0; k < NUM_AUX; k++) begin : g_aux
      localparam logic [39:0] MAP = aux_map(k);
      logic [4:0] grp_ok;
      logic [7:0] cfg;
      logic mute_act;
      assign cfg = s_r.aux[k];
      for (genvar j = 0; j < 5; j++) begin : g_grp
         localparam logic [7:0] M = MAP[8*j +: 8];
         assign grp_ok[j] = &(src_s.chan_mute | ~M);
      end
      // mapped mutes combine like the summary pin
      assign mute_act = &(~cfg[4:0] | grp_ok);
      always_comb begin
         unique case (cfg[7:6])
            `CIP_MODE_MUTE: begin
               aux_lvl[k] = cfg[`CIP_POL_BIT] ? mute_act : ~mute_act;
               aux_en[k] = 1'h1;
            end
            `CIP_MODE_LOW_OVFL: begin
               // polarity is not looked at in this mode
               aux_lvl[k] = 1'h0;
               if (cfg[1:0] == `CIP_FUNC_LOW) begin
                  aux_en[k] = 1'h1;
               end else if (cfg[1:0] == `CIP_FUNC_OVFL) begin
                  // open drain: the pin only sinks, the board pull-up makes the high
                  aux_en[k] = range_any;
               end else begin
                  aux_en[k] = 1'h0;
               end
            end
            `CIP_MODE_HIGH: begin
               aux_lvl[k] = 1'h1;
               aux_en[k] = 1'h1;
            end
            default: begin
               // reserved mode leaves the pin undriven
               aux_lvl[k] = 1'h0;
               aux_en[k] = 1'h0;
            end
         endcase
      end
   end

   // ==========================================================================
   // register read view; aux index counts down from the first address
   always_comb begin
      rk = 3'(`CIP_IDX_AUX_LAST - a_idx);
      rd_byte = 8'h00;
      unique case (a_idx)
         `CIP_IDX_CTRL: rd_byte = s_nxt.ctrl;
         `CIP_IDX_FLAGS: rd_byte = s_r.flags & s_r.enables;
         `CIP_IDX_ENABLES: rd_byte = s_nxt.enables;
         `CIP_IDX_TRIG_HI: rd_byte = s_nxt.trig_hi;
         `CIP_IDX_TRIG_LO: rd_byte = s_nxt.trig_lo;
         `CIP_IDX_MUTE_SUM: rd_byte = s_nxt.mute_ctl;
         default: begin
            if (a_idx >= `CIP_IDX_AUX_FIRST && a_idx <= `CIP_IDX_AUX_LAST) begin
               rd_byte = s_nxt.aux[rk];
            end
         end
      endcase
      // unaligned addresses read as zero rather than aliasing a neighbour
      if (!a_ok) begin
         rd_byte = 8'h00;
      end
   end

   // ==========================================================================
   // next state: bus writes land in the data phase, reads other than the flags are answered
   // from the state after that write so a write then read sees new data; flags read the registered flags and enables
   always_comb begin
      s_nxt = s_r;
      acc = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
      a_idx = ahb_i.haddr[7:2];
      a_ok = (ahb_i.haddr[1:0] == 2'h0);
      wb = ahb_i.hwdata[7:0];
      wk = 3'(`CIP_IDX_AUX_LAST - s_r.wr_idx);
      rd_clr = 1'h0;

      // data phase of a write; unmapped addresses are ignored
      if (s_r.wr_pend) begin
         unique case (s_r.wr_idx)
            `CIP_IDX_CTRL: s_nxt.ctrl = wb & `CIP_CTRL_WMASK;
            `CIP_IDX_ENABLES: s_nxt.enables = wb & `CIP_EVT_MASK;
            `CIP_IDX_TRIG_HI: s_nxt.trig_hi = wb & `CIP_EVT_MASK;
            `CIP_IDX_TRIG_LO: s_nxt.trig_lo = wb & `CIP_EVT_MASK;
            `CIP_IDX_MUTE_SUM: s_nxt.mute_ctl = wb & `CIP_MUTE_SUM_WMASK;
            default: begin
               if (s_r.wr_idx >= `CIP_IDX_AUX_FIRST && s_r.wr_idx <= `CIP_IDX_AUX_LAST) begin
                  s_nxt.aux[wk] = wb;
               end
            end
         endcase
      end

      // address phase
      // an unaligned write is dropped here, so it never reaches a register
      s_nxt.wr_pend = acc & a_ok & ahb_i.hwrite;
      s_nxt.wr_idx = a_idx;
      if (acc && !ahb_i.hwrite) begin
         s_nxt.rdata = {24'h00_0000, rd_byte};
         rd_clr = a_ok & (a_idx == `CIP_IDX_FLAGS);
      end
      // zero wait states: the slave never stretches a transfer
      s_nxt.rdy = 1'h1;

      // flags: clear on read, but an event in the same cycle still lands
      s_nxt.cond_prev = cond_now;
      s_nxt.flags = ((rd_clr ? 8'h00 : s_r.flags) | evt) & s_nxt.enables;

      // pin level follows the next flags through the style field, never the trigger codes directly
      irq_act = |s_nxt.flags;
      unique case (s_r.ctrl[`CIP_STYLE_MSB:`CIP_STYLE_LSB])
         `CIP_STYLE_HIGH: begin
            s_nxt.irq_pin = irq_act;
            s_nxt.irq_oe = 1'h1;
         end
         `CIP_STYLE_LOW: begin
            s_nxt.irq_pin = ~irq_act;
            s_nxt.irq_oe = 1'h1;
         end
         `CIP_STYLE_OD: begin
            s_nxt.irq_pin = 1'h0;
            s_nxt.irq_oe = irq_act;
         end
         default: begin
            // reserved style: do not fight whatever else sits on the wire
            s_nxt.irq_pin = 1'h0;
            s_nxt.irq_oe = 1'h0;
         end
      endcase

      // summary pin polarity
      s_nxt.msum = s_r.mute_ctl[`CIP_POL_BIT] ? sum_act : ~sum_act;
      s_nxt.aux_pin = aux_lvl;
      s_nxt.aux_oe = aux_en;
   end

   // ==========================================================================
   // state register; one register for the whole state keeps the reset
   // image and the next-state logic in step
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_r <= RST_S;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================================
   // outputs straight from the state register, except the response, which is tied off
   assign hrdata_o = s_r.rdata;
   assign hreadyout_o = s_r.rdy;
   // the response is fixed at OKAY: no access is ever refused
   assign hresp_o = 1'h0;
   assign irq_pin_o = s_r.irq_pin;
   assign irq_pin_oe_o = s_r.irq_oe;
   assign mute_summary_o = s_r.msum;
   assign aux_output_pin_o = s_r.aux_pin;
   assign aux_output_pin_oe_o = s_r.aux_oe;

endmodule : cip_irq_pins

// File: tb/cip_ext_model.sv
`timescale 1ns/1ps

// ====
// board side of the pins: pull-ups on every pin that may be released
module cip_ext_model #(
   parameter int NUM_AUX = 7
) (
   input wire logic irq_pin_i,
   input wire logic irq_oe_i,
   input wire logic [NUM_AUX-1:0] aux_pin_i,
   input wire logic [NUM_AUX-1:0] aux_oe_i,
   output logic irq_wire_o,
   output logic [NUM_AUX-1:0] aux_wire_o
);
   // a released pin floats up, so an open-drain flag reads high when idle
   assign irq_wire_o = irq_oe_i ? irq_pin_i : 1'b1;
   assign aux_wire_o = (aux_pin_i & aux_oe_i) | ~aux_oe_i;
endmodule : cip_ext_model

// File: tb/cip_irq_pins_properties.sv
`timescale 1ns/1ps

// ====
// checker: shadows the control, enable and mute summary registers from the bus it watches
module cip_irq_pins_props #(
   parameter int NUM_AUX = 7
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire cip_pkg::cip_ahb_req_t ahb_i,
   input wire logic [31:0] hrdata_o,
   input wire cip_pkg::cip_src_t src_i,
   input wire logic irq_pin_o,
   input wire logic irq_pin_oe_o,
   input wire logic mute_summary_o,
   input wire logic [NUM_AUX-1:0] aux_output_pin_oe_o
);
   logic wp_r;
   logic [5:0] wi_r;
   logic [7:0] ctl_r, enb_r, mc_r;
   logic [3:0] q_r;
   wire acc = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
   wire rd_fl = acc & !ahb_i.hwrite & (ahb_i.haddr == 8'h80);
   // settle leaves two edges after a write, since the pins are registered
   wire settle = (q_r >= 4'h2) && !wp_r;

   // shadow registers updated in the data phase, like the slave
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wp_r <= 1'b0;
         wi_r <= 6'h00;
         ctl_r <= 8'h00;
         enb_r <= 8'h00;
         mc_r <= 8'h1F;
         q_r <= 4'h0;
      end else begin
         wp_r <= acc & ahb_i.hwrite;
         wi_r <= ahb_i.haddr[7:2];
         q_r <= wp_r ? 4'h0 : ((q_r == 4'hF) ? q_r : q_r + 4'h1);
         if (wp_r && wi_r == 6'h1E) ctl_r <= ahb_i.hwdata[7:0];
         if (wp_r && wi_r == 6'h21) enb_r <= ahb_i.hwdata[7:0];
         if (wp_r && wi_r == 6'h28) mc_r <= ahb_i.hwdata[7:0];
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence s_quiet;
      (!src_i.lost_lock && !src_i.range_left && !src_i.range_right)[*8];
   endsequence
   sequence s_two_reads;
      rd_fl ##2 rd_fl;
   endsequence
   property p_rc_clear;
      s_quiet ##0 s_two_reads |=> hrdata_o == 32'h0000_0000;
   endproperty
   property p_mask_zero;
      rd_fl && settle |=> (hrdata_o[7:0] & ~enb_r) == 8'h00;
   endproperty
   property p_style_pp;
      settle && !ctl_r[3] |-> irq_pin_oe_o;
   endproperty
   property p_style_od;
      settle && ctl_r[3:2] == 2'b10 |-> !(irq_pin_oe_o && irq_pin_o);
   endproperty
   property p_irq_idle;
      settle && enb_r == 8'h00 && !ctl_r[3] |-> irq_pin_o == ctl_r[2];
   endproperty
   property p_msum_none;
      settle && mc_r[4:0] == 5'h00 |-> mute_summary_o == mc_r[5];
   endproperty
   property p_msum_all;
      (src_i.chan_mute == 8'hFF)[*7] ##0 settle |-> mute_summary_o == mc_r[5];
   endproperty
   property p_msum_free;
      (src_i.chan_mute == 8'h00)[*7] ##0 (settle && mc_r[4:0] != 5'h00)
         |-> mute_summary_o != mc_r[5];
   endproperty
   property p_rst_pins;
      $fell(rst_i) |-> aux_output_pin_oe_o == '0 && mute_summary_o && !irq_pin_o;
   endproperty

   a_rc_clear: assert property (p_rc_clear)
      else $error("flags not cleared by read");
   a_mask_zero: assert property (p_mask_zero)
      else $error("masked flag read as one");
   a_style_pp: assert property (p_style_pp)
      else $error("push-pull irq pin not driven");
   a_style_od: assert property (p_style_od)
      else $error("open-drain irq pin driven high");
   a_irq_idle: assert property (p_irq_idle)
      else $error("idle irq level wrong");
   a_msum_none: assert property (p_msum_none)
      else $error("summary pin not active with no selects");
   a_msum_all: assert property (p_msum_all)
      else $error("summary pin not active with all muted");
   a_msum_free: assert property (p_msum_free)
      else $error("summary pin active with nothing muted");
   a_rst_pins: assert property (p_rst_pins)
      else $error("pins wrong after reset");
endmodule : cip_irq_pins_props

bind cip_irq_pins cip_irq_pins_props #(.NUM_AUX(NUM_AUX)) chk_u (
   .mclk_i(mclk_i),
   .rst_i(rst_i),
   .ahb_i(ahb_i),
   .hrdata_o(hrdata_o),
   .src_i(src_i),
   .irq_pin_o(irq_pin_o),
   .irq_pin_oe_o(irq_pin_oe_o),
   .mute_summary_o(mute_summary_o),
   .aux_output_pin_oe_o(aux_output_pin_oe_o)
);

// File: tb/cip_irq_pins_tb.sv
`timescale 1ns/1ps

`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("BAD %s exp %h got %h", n, e, g); end end

module cip_irq_pins_tb;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   cip_pkg::cip_ahb_req_t req = '0;
   cip_pkg::cip_ahb_req_t ahb_in;
   cip_pkg::cip_src_t src = '0;
   logic [31:0] hrdata;
   logic hrdy, hresp, irq_pin, irq_oe, msum, irq_w;
   logic [6:0] aux_pin, aux_oe, aux_w;
   logic [31:0] rd;
   int fails = 0;
   int checks = 0;
   int cyc = 0;
   // aux cases: config, mutes, overflow, wire, drive enable
   logic [7:0] ac[12] = '{8'hE0, 8'hC0, 8'h80, 8'hA0, 8'h83, 8'h83, 8'h5F, 8'h7F, 8'h7F,
      8'h50, 8'h00, 8'h81};
   logic [7:0] am[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFE,
      8'h03, 8'h00, 8'h00};
   // bit i of each word belongs to aux case i
   logic [11:0] ar = 12'h820;
   logic [11:0] aw = 12'hC93;
   logic [11:0] ao = 12'h3EF;
   // summary cases: control, mutes, pin
   logic [7:0] mc[8] = '{8'h1F, 8'h1F, 8'h30, 8'h30, 8'h20, 8'h00, 8'h21, 8'h21};
   logic [7:0] mm[8] = '{8'hFF, 8'hFE, 8'h01, 8'hFE, 8'h00, 8'h00, 8'h40, 8'hC0};
   logic [7:0] me = 8'h96;

   // hready of the single slave closes the loop back to the master side
   assign ahb_in = {req[47:1], hrdy};

   cip_irq_pins dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .ahb_i(ahb_in), .hrdata_o(hrdata),
      .hreadyout_o(hrdy), .hresp_o(hresp), .src_i(src), .irq_pin_o(irq_pin),
      .irq_pin_oe_o(irq_oe), .mute_summary_o(msum), .aux_output_pin_o(aux_pin),
      .aux_output_pin_oe_o(aux_oe));
   cip_ext_model ext_u (.irq_pin_i(irq_pin), .irq_oe_i(irq_oe), .aux_pin_i(aux_pin),
      .aux_oe_i(aux_oe), .irq_wire_o(irq_w), .aux_wire_o(aux_w));

   initial forever #12.5 mclk_i = ~mclk_i;

   // ====
   // hang guard
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_of_test();
      end
   end

   // ====
   // bus cycles: address phase held until hready, then data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      req.hsel <= 1'b1;
      req.htrans <= 2'b10;
      req.haddr <= a;
      req.hwrite <= w;
      req.hsize <= 3'b010;
      do @(posedge mclk_i); while (hrdy !== 1'b1);
      req.hsel <= 1'b0;
      req.htrans <= 2'b00;
      req.hwdata <= {24'h00_0000, d};
      do @(posedge mclk_i); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic chk_rd(input string n, input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      `CHK(n, {24'h00_0000, e}, rd)
   endtask : chk_rd

   // inputs pass a synchroniser, so give them time to land
   task automatic idle8;
      repeat (8) @(posedge mclk_i);
   endtask : idle8

   task automatic lock_pulse;
      src.lost_lock <= 1'b1;
      idle8();
      src.lost_lock <= 1'b0;
      idle8();
   endtask : lock_pulse

   // ====
   // scenarios
   task automatic t_reset;
      chk_rd("ctrl", 8'h78, 8'h00);
      `CHK("hresp", 1'b0, hresp)
      chk_rd("enables", 8'h84, 8'h00);
      chk_rd("trig_hi", 8'h88, 8'h00);
      chk_rd("trig_lo", 8'h8C, 8'h00);
      chk_rd("mute_ctl", 8'hA0, 8'h1F);
      chk_rd("aux7", 8'hA4, 8'h00);
      chk_rd("aux1", 8'hBC, 8'h00);
      chk_rd("unmapped", 8'hFC, 8'h00);
      chk_rd("flags", 8'h80, 8'h00);
   endtask : t_reset

   task automatic t_level;
      wr(8'h84, 8'h82);
      wr(8'h88, 8'h82);
      lock_pulse();
      chk_rd("lock_flag", 8'h80, 8'h80);
      chk_rd("cleared", 8'h80, 8'h00);
      for (int i = 0; i < 2; i++) begin
         if (i == 0) src.range_left <= 1'b1;
         else src.range_right <= 1'b1;
         idle8();
         src.range_left <= 1'b0;
         src.range_right <= 1'b0;
         idle8();
         chk_rd("range_flag", 8'h80, 8'h02);
      end
      wr(8'h84, 8'h00);
      lock_pulse();
      chk_rd("masked", 8'h80, 8'h00);
   endtask : t_level

   task automatic t_edges;
      wr(8'h84, 8'h82);
      wr(8'h88, 8'h00);
      src.lost_lock <= 1'b1;
      idle8();
      chk_rd("rise", 8'h80, 8'h80);
      chk_rd("rise_once", 8'h80, 8'h00);
      src.lost_lock <= 1'b0;
      idle8();
      chk_rd("no_fall", 8'h80, 8'h00);
      wr(8'h8C, 8'h82);
      src.lost_lock <= 1'b1;
      idle8();
      chk_rd("fall_wait", 8'h80, 8'h00);
      src.lost_lock <= 1'b0;
      idle8();
      chk_rd("fall", 8'h80, 8'h80);
      wr(8'h88, 8'h82);
      lock_pulse();
      chk_rd("reserved", 8'h80, 8'h00);
      wr(8'h8C, 8'h00);
   endtask : t_edges

   task automatic t_irq;
      for (int s = 0; s < 4; s++) begin
         wr(8'h78, 8'(s << 2));
         chk_rd("flags_pre", 8'h80, 8'h00);
         idle8();
         `CHK("irq_idle", s != 0, irq_w)
         `CHK("irq_oe", s < 2, irq_oe)
         src.lost_lock <= 1'b1;
         idle8();
         `CHK("irq_act", s == 0 || s == 3, irq_w)
         src.lost_lock <= 1'b0;
         idle8();
         chk_rd("flags_post", 8'h80, 8'h80);
      end
   endtask : t_irq

   task automatic t_msum;
      for (int i = 0; i < 8; i++) begin
         wr(8'hA0, mc[i]);
         src.chan_mute <= mm[i];
         idle8();
         `CHK("mute_summary", me[i], msum)
      end
   endtask : t_msum

   task automatic t_aux;
      for (int i = 0; i < 12; i++) begin
         wr(8'hA4, ac[i]);
         src.chan_mute <= am[i];
         src.range_left <= ar[i];
         idle8();
         `CHK("aux_wire", aw[i], aux_w[6])
         `CHK("aux_oe", ao[i], aux_oe[6])
      end
      src.range_left <= 1'b0;
      wr(8'hBC, 8'h80);
      idle8();
      `CHK("aux1_low", 1'b0, aux_w[0])
   endtask : t_aux

   task automatic end_of_test;
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (10) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      t_reset();
      t_level();
      t_edges();
      t_irq();
      t_msum();
      t_aux();
      end_of_test();
   end
endmodule : cip_irq_pins_tb
